// File: design/shbgs_top.sv
// Static half-bridge gate sequencer, eight bridges
// Summary of operation
// R1: Unmapped bridge: 01 low-side, 10 high-side static
// R2: Per-bridge 4-bit static current code
// R3: Hard-off uses pwm discharge code 31
// R4: Hold select clear: hold codes 12.5/14.2 mA
// R5: Hold select set: hold codes 23.9/26.0 mA
// R6: Faults force static discharge; overcurrent gated
// R7: 01 to 10: guard phase, both discharge
// R8: Then charge, opposite hard-off, blank plus filter
// R9: After filter, hold charge and hold discharge
// R10: 00 to 10 skips guard phase
// R11: Low-side turn-on mirrors high-side sequence
// R12: Mode 00/11: discharge for guard, then hold
// R13: Synchronise chip-select rise; apply within 3 us
// R14: Per-bridge guard and blank times configurable
// R15: Mode 11 reserved, same as 00
// R16: Active when passive control clear; reset passive
// R17: Phase durations are down-counters reaching zero
`timescale 1ns/10ps
module shbgs_top
  import shbgs_pkg::*;
#(
  parameter int unsigned NB = shbgs_pkg::NUM_BRIDGES,
  parameter int unsigned TW = shbgs_pkg::TIME_W
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic cs_n_i,
  input wire logic [2*NB-1:0] half_bridge_mode_sel_i,
  input wire logic [NB-1:0] pwm_mapped_i,
  input wire logic bridge_passive_ctl_i,
  input wire logic [4*NB-1:0] static_gate_current_code_i,
  input wire logic hold_current_sel_i,
  input wire logic [TW*NB-1:0] guard_cyc_i,
  input wire logic [TW*NB-1:0] blank_cyc_i,
  input wire logic [TW-1:0] filter_cyc_i,
  input wire logic overcurrent_shutdown_en_i,
  input wire logic fault_supply_i,
  input wire logic fault_temp_i,
  input wire logic fault_vds_i,
  input wire logic fault_cp_i,
  input wire logic fault_oc_i,
  output logic [2*NB-1:0] hs_action_o,
  output logic [2*NB-1:0] ls_action_o,
  output logic [4*NB-1:0] hs_level_o,
  output logic [4*NB-1:0] ls_level_o,
  output logic [NB-1:0] hs_hard_off_o,
  output logic [NB-1:0] ls_hard_off_o,
  output logic [4:0] hard_off_code_o,
  output logic active_o,
  output logic fault_off_o
);
  import shbgs_pkg::*;

  typedef struct packed {
    logic [2:0] cs_sync;
    logic [4:0] flt_s1;
    logic [4:0] flt_s2;
    logic apply;
    logic active;
    logic fault;
    logic [4*NB-1:0] hs_lvl;
    logic [4*NB-1:0] ls_lvl;
  } shbgs_top_t;

  shbgs_top_t st_reg, st_next;
  logic [2*NB-1:0] hs_act_w, ls_act_w;
  logic [NB-1:0] hs_hard_w, ls_hard_w;
  logic [4*NB-1:0] hs_lvl_w, ls_lvl_w;
  logic [4:0] flt_raw;

  assign flt_raw = {fault_supply_i, fault_temp_i, fault_vds_i, fault_cp_i, fault_oc_i};

  always_comb begin
    st_next = st_reg;
    st_next.cs_sync = {st_reg.cs_sync[1:0], cs_n_i}; // R13
    st_next.flt_s1 = flt_raw;
    st_next.flt_s2 = st_reg.flt_s1;
    // Apply commands one cycle after synchronised rise
    st_next.apply = st_reg.cs_sync[1] & ~st_reg.cs_sync[2]; // R13
    st_next.active = ~bridge_passive_ctl_i; // R16
    st_next.fault = st_reg.active & (|st_reg.flt_s2[4:1] |
                    (st_reg.flt_s2[0] & overcurrent_shutdown_en_i)); // R6
    st_next.hs_lvl = hs_lvl_w; // R2 R4 R5
    st_next.ls_lvl = ls_lvl_w; // R2 R4 R5
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= '0;
      st_reg.cs_sync <= 3'h7;
      st_reg.active <= ~PASSIVE_RST; // R16
    end else begin
      st_reg <= st_next;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_br
      logic [1:0] mode_eff;
      logic [3:0] hold_on, hold_off;
      // Mapped bridges are forced to mode 00: static drive goes to hold-off
      assign mode_eff = pwm_mapped_i[gi] ? MODE_OFF : half_bridge_mode_sel_i[2*gi +: 2]; // R1
      assign hold_on = hold_current_sel_i ? HOLD_HIGH_CODE : HOLD_LOW_CODE; // R4 R5
      assign hold_off = hold_on;
      shbgs_bridge #(.TW(TW)) u_br (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .apply_i(st_reg.apply),
        .active_i(st_reg.active),
        .fault_i(st_reg.fault),
        .mode_i(mode_eff),
        .guard_cyc_i(guard_cyc_i[TW*gi +: TW]), // R14
        .blank_cyc_i(blank_cyc_i[TW*gi +: TW]), // R14
        .filter_cyc_i(filter_cyc_i),
        .hs_act_o(hs_act_w[2*gi +: 2]),
        .ls_act_o(ls_act_w[2*gi +: 2]),
        .hs_hard_off_o(hs_hard_w[gi]),
        .ls_hard_off_o(ls_hard_w[gi]),
        .phase_o()
      );
      // Level chosen per bridge, registered with the actions
      assign hs_lvl_w[4*gi +: 4] = (hs_act_w[2*gi +: 2] == SHBGS_DRV_HOLD_ON) ? hold_on :
        (hs_act_w[2*gi +: 2] == SHBGS_DRV_HOLD_OFF) ? hold_off : static_gate_current_code_i[4*gi +: 4]; // R2
      assign ls_lvl_w[4*gi +: 4] = (ls_act_w[2*gi +: 2] == SHBGS_DRV_HOLD_ON) ? hold_on :
        (ls_act_w[2*gi +: 2] == SHBGS_DRV_HOLD_OFF) ? hold_off : static_gate_current_code_i[4*gi +: 4]; // R2
    end
  endgenerate

  assign hs_level_o = st_reg.hs_lvl;
  assign ls_level_o = st_reg.ls_lvl;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hs_action_o <= '0;
      ls_action_o <= '0;
      hs_hard_off_o <= '0;
      ls_hard_off_o <= '0;
      hard_off_code_o <= 5'h00;
      active_o <= 1'b0;
      fault_off_o <= 1'b0;
    end else begin
      hs_action_o <= hs_act_w;
      ls_action_o <= ls_act_w;
      hs_hard_off_o <= hs_hard_w;
      ls_hard_off_o <= ls_hard_w;
      hard_off_code_o <= HARD_OFF_CODE; // R3
      active_o <= st_reg.active;
      fault_off_o <= st_reg.fault;
    end
  end
endmodule

// File: include/shbgs_pkg.sv
// Package for the static half-bridge gate sequencer
package shbgs_pkg;
  localparam int unsigned NUM_BRIDGES = 8;
  localparam int unsigned TIME_W = 16;
  // Mode codes per half-bridge
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_LS_ON = 2'h1;
  localparam logic [1:0] MODE_HS_ON = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  // Hold level codes (index into static current table)
  localparam logic [3:0] HOLD_LOW_CODE = 4'h4;
  localparam logic [3:0] HOLD_HIGH_CODE = 4'h6;
  // Pwm discharge code giving the hard-off sink level
  localparam logic [4:0] HARD_OFF_CODE = 5'h1f;
  // Command latency limit after chip-select rise
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned CMD_DELAY_US = 3;
  localparam int unsigned CMD_DELAY_CYC = CMD_DELAY_US * CLK_MHZ;
  // Reset values
  localparam logic PASSIVE_RST = 1'b1;
  localparam logic [1:0] MODE_RST = 2'h0;
  // Gate drive action per switch
  typedef enum logic [1:0] {
    SHBGS_DRV_HOLD_OFF = 2'b00,
    SHBGS_DRV_DISCHARGE = 2'b01,
    SHBGS_DRV_CHARGE = 2'b10,
    SHBGS_DRV_HOLD_ON = 2'b11
  } shbgs_drv_t;
endpackage

// File: design/shbgs_bridge.sv
// Sequencer for one half-bridge
`timescale 1ns/10ps
module shbgs_bridge
  import shbgs_pkg::*;
#(
  parameter int unsigned TW = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic apply_i,
  input wire logic active_i,
  input wire logic fault_i,
  input wire logic [1:0] mode_i,
  input wire logic [TW-1:0] guard_cyc_i,
  input wire logic [TW-1:0] blank_cyc_i,
  input wire logic [TW-1:0] filter_cyc_i,
  output logic [1:0] hs_act_o,
  output logic [1:0] ls_act_o,
  output logic hs_hard_off_o,
  output logic ls_hard_off_o,
  output logic [1:0] phase_o
);
  typedef enum logic [2:0] {
    SHBGS_PH_IDLE = 3'b000,
    SHBGS_PH_GUARD = 3'b001,
    SHBGS_PH_CHARGE = 3'b010,
    SHBGS_PH_FILTER = 3'b011,
    SHBGS_PH_HOLD = 3'b100,
    SHBGS_PH_FAULT = 3'b101
  } shbgs_ph_t;

  typedef struct packed {
    shbgs_ph_t ph;
    logic [1:0] mode;
    logic [TW-1:0] cnt;
    logic [1:0] hs;
    logic [1:0] ls;
    logic hs_hard;
    logic ls_hard;
  } shbgs_br_t;

  shbgs_br_t st_reg, st_next;
  logic on_hs, on_ls;

  always_comb begin
    st_next = st_reg;
    on_hs = (st_reg.mode == MODE_HS_ON);
    on_ls = (st_reg.mode == MODE_LS_ON);
    if (!active_i) begin
      st_next.ph = SHBGS_PH_IDLE;
      st_next.mode = MODE_RST;
    end else if (fault_i) begin
      st_next.ph = SHBGS_PH_FAULT; // R6
    end else if (apply_i && mode_i != st_reg.mode) begin
      st_next.mode = mode_i;
      if (mode_i == MODE_HS_ON || mode_i == MODE_LS_ON) begin
        if (st_reg.mode == MODE_OFF || st_reg.mode == MODE_RSVD) begin
          st_next.ph = SHBGS_PH_CHARGE; // R10
          st_next.cnt = blank_cyc_i; // R17
        end else begin
          st_next.ph = SHBGS_PH_GUARD; // R7
          st_next.cnt = guard_cyc_i; // R17
        end
      end else begin
        st_next.ph = SHBGS_PH_GUARD; // R12 R15
        st_next.cnt = guard_cyc_i;
      end
    end else if (st_reg.ph == SHBGS_PH_FAULT) begin
      st_next.ph = SHBGS_PH_FAULT;
    end else if (st_reg.ph != SHBGS_PH_IDLE && st_reg.ph != SHBGS_PH_HOLD) begin
      if (st_reg.cnt != '0) begin
        st_next.cnt = st_reg.cnt - TW'(1); // R17
      end else begin
        unique case (st_reg.ph)
          SHBGS_PH_GUARD: begin
            if (on_hs || on_ls) begin
              st_next.ph = SHBGS_PH_CHARGE; // R8
              st_next.cnt = blank_cyc_i;
            end else begin
              st_next.ph = SHBGS_PH_HOLD; // R12
            end
          end
          SHBGS_PH_CHARGE: begin
            st_next.ph = SHBGS_PH_FILTER; // R8
            st_next.cnt = filter_cyc_i;
          end
          default: st_next.ph = SHBGS_PH_HOLD; // R9
        endcase
      end
    end
    // Drive actions per phase; low-side mirrors high-side
    st_next.hs_hard = 1'b0;
    st_next.ls_hard = 1'b0;
    unique case (st_next.ph)
      SHBGS_PH_IDLE, SHBGS_PH_HOLD: begin
        st_next.hs = (st_next.mode == MODE_HS_ON) ? SHBGS_DRV_HOLD_ON : SHBGS_DRV_HOLD_OFF; // R9
        st_next.ls = (st_next.mode == MODE_LS_ON) ? SHBGS_DRV_HOLD_ON : SHBGS_DRV_HOLD_OFF; // R11
      end
      SHBGS_PH_GUARD, SHBGS_PH_FAULT: begin
        st_next.hs = SHBGS_DRV_DISCHARGE; // R7
        st_next.ls = SHBGS_DRV_DISCHARGE; // R6
      end
      default: begin
        st_next.hs = (st_next.mode == MODE_HS_ON) ? SHBGS_DRV_CHARGE : SHBGS_DRV_HOLD_OFF; // R8
        st_next.ls = (st_next.mode == MODE_LS_ON) ? SHBGS_DRV_CHARGE : SHBGS_DRV_HOLD_OFF; // R11
        st_next.hs_hard = (st_next.mode == MODE_LS_ON); // R3
        st_next.ls_hard = (st_next.mode == MODE_HS_ON); // R3
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= '{ph: SHBGS_PH_IDLE, mode: MODE_RST, cnt: '0, hs: SHBGS_DRV_HOLD_OFF,
                  ls: SHBGS_DRV_HOLD_OFF, hs_hard: 1'b0, ls_hard: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign hs_act_o = st_reg.hs;
  assign ls_act_o = st_reg.ls;
  assign hs_hard_off_o = st_reg.hs_hard;
  assign ls_hard_off_o = st_reg.ls_hard;
  assign phase_o = st_reg.ph[1:0];
endmodule

// File: tb/shbgs_monitor.sv
// Checker for the static half-bridge gate sequencer
`timescale 1ns/10ps
module shbgs_monitor
  import shbgs_pkg::*;
#(
  parameter int unsigned NB = 8,
  parameter int unsigned TW = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic bridge_passive_ctl_i,
  input wire logic [4*NB-1:0] static_gate_current_code_i,
  input wire logic hold_current_sel_i,
  input wire logic overcurrent_shutdown_en_i,
  input wire logic fault_supply_i,
  input wire logic fault_temp_i,
  input wire logic fault_vds_i,
  input wire logic fault_cp_i,
  input wire logic [2*NB-1:0] hs_action_o,
  input wire logic [2*NB-1:0] ls_action_o,
  input wire logic [4*NB-1:0] hs_level_o,
  input wire logic [4*NB-1:0] ls_level_o,
  input wire logic [NB-1:0] hs_hard_off_o,
  input wire logic [NB-1:0] ls_hard_off_o,
  input wire logic [4:0] hard_off_code_o,
  input wire logic active_o,
  input wire logic fault_off_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic other_flt;
  assign other_flt = fault_supply_i | fault_temp_i | fault_vds_i | fault_cp_i;
  a_hard_off_code: assert property (
    !$past(srst_i) && !$past(srst_i, 2) |-> hard_off_code_o == HARD_OFF_CODE) else $error("hard-off code wrong");
  a_no_cross_on: assert property (
    !(hs_action_o[1] && ls_action_o[1])) else $error("both switches driven on");
  a_hold_level: assert property (
    hs_action_o[1:0] == SHBGS_DRV_HOLD_ON && hold_current_sel_i == $past(hold_current_sel_i, 3)
    |-> hs_level_o[3:0] == (hold_current_sel_i ? HOLD_HIGH_CODE : HOLD_LOW_CODE)) else $error("hold level wrong");
  a_charge_hard_off: assert property (
    hs_action_o[1:0] == SHBGS_DRV_CHARGE |-> hs_level_o[3:0] == static_gate_current_code_i[3:0] && ls_hard_off_o[0])
    else $error("charge phase wrong");
  a_ls_charge_mirror: assert property (
    ls_action_o[1:0] == SHBGS_DRV_CHARGE |-> hs_hard_off_o[0]) else $error("low-side charge without hard-off");
  a_ls_charge_level: assert property (
    ls_action_o[1:0] == SHBGS_DRV_CHARGE |-> ls_level_o[3:0] == static_gate_current_code_i[3:0])
    else $error("low-side charge level wrong");
  a_fault_turns_off: assert property (
    $rose(fault_temp_i) && active_o |-> ##[1:6] fault_off_o) else $error("fault not acted on");
  a_oc_gated: assert property (
    (!overcurrent_shutdown_en_i && !other_flt) [*8] |-> !fault_off_o) else $error("ungated fault shutdown");
  a_passive_idle: assert property (
    bridge_passive_ctl_i [*5] |-> !active_o) else $error("active while passive");
  c_charge_hold: cover property (hs_action_o[1:0] == SHBGS_DRV_CHARGE ##[1:20] hs_action_o[1:0] == SHBGS_DRV_HOLD_ON);
  c_guard: cover property (hs_action_o[1:0] == SHBGS_DRV_DISCHARGE && ls_action_o[1:0] == SHBGS_DRV_DISCHARGE);
  c_fault: cover property ($rose(fault_off_o));
endmodule
bind shbgs_top shbgs_monitor #(.NB(NB), .TW(TW)) mon (.clk_i, .srst_i, .bridge_passive_ctl_i,
  .static_gate_current_code_i, .hold_current_sel_i, .overcurrent_shutdown_en_i, .fault_supply_i, .fault_temp_i,
  .fault_vds_i, .fault_cp_i, .hs_action_o, .ls_action_o, .hs_level_o, .ls_level_o, .hs_hard_off_o, .ls_hard_off_o,
  .hard_off_code_o, .active_o, .fault_off_o);

// File: tb/shbgs_fet_model.sv
// Behavioural switch pairs, gates follow drive one cycle late
`timescale 1ns/10ps
module shbgs_fet_model #(
  parameter int unsigned NB = 8
) (
  input wire logic clk_i,
  input wire logic [2*NB-1:0] gate_hs_i,
  input wire logic [2*NB-1:0] gate_ls_i,
  output logic [NB-1:0] hs_on_o,
  output logic [NB-1:0] ls_on_o,
  output logic shoot_o
);
  always_ff @(posedge clk_i) begin
    for (int b = 0; b < NB; b++) begin
      hs_on_o[b] <= gate_hs_i[2*b+1];
      ls_on_o[b] <= gate_ls_i[2*b+1];
    end
  end
  assign shoot_o = |(hs_on_o & ls_on_o);
endmodule

// File: tb/shbgs_top_test.sv
// Self-checking bench for the static half-bridge gate sequencer
`timescale 1ns/10ps
module shbgs_top_test;
  import shbgs_pkg::*;
  typedef struct packed {logic [1:0] m; logic h; logic g; logic c; logic [3:0] e;} shbgs_row_t;
  logic clk, srst, cs_n, pas, hold, overcurrent_shutdown_en, act, foff, shoot;
  logic shot = 1'b0;
  logic [7:0] pmap;
  logic [4:0] flt, hoc;
  logic [1:0] mode;
  logic [15:0] hs_a, ls_a;
  logic [31:0] hs_l;
  logic [7:0] hs_on, ls_on;
  int err_total, checks;
  shbgs_row_t rows [6] = '{'{2'h1, 1'h0, 1'h0, 1'h1, 4'h3}, '{2'h2, 1'h1, 1'h1, 1'h1, 4'hc},
    '{2'h1, 1'h0, 1'h1, 1'h1, 4'h3}, '{2'h0, 1'h1, 1'h1, 1'h0, 4'h0}, '{2'h2, 1'h0, 1'h0, 1'h1, 4'hc},
    '{2'h3, 1'h0, 1'h1, 1'h0, 4'h0}};
  shbgs_top #(.NB(8), .TW(16)) dut (.clk_i(clk), .srst_i(srst), .cs_n_i(cs_n), .half_bridge_mode_sel_i({8{mode}}),
    .pwm_mapped_i(pmap), .bridge_passive_ctl_i(pas), .static_gate_current_code_i({8{4'ha}}),
    .hold_current_sel_i(hold), .guard_cyc_i({8{16'h0002}}), .blank_cyc_i({8{16'h0002}}), .filter_cyc_i(16'h0001),
    .overcurrent_shutdown_en_i(overcurrent_shutdown_en), .fault_supply_i(flt[0]), .fault_temp_i(flt[1]), .fault_vds_i(flt[2]),
    .fault_cp_i(flt[3]), .fault_oc_i(flt[4]), .hs_action_o(hs_a), .ls_action_o(ls_a), .hs_level_o(hs_l),
    .ls_level_o(), .hs_hard_off_o(), .ls_hard_off_o(), .hard_off_code_o(hoc), .active_o(act), .fault_off_o(foff));
  shbgs_fet_model #(.NB(8)) fets (.clk_i(clk), .gate_hs_i(hs_a), .gate_ls_i(ls_a), .hs_on_o(hs_on),
    .ls_on_o(ls_on), .shoot_o(shoot));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk) if (shoot === 1'b1) shot = 1;
  task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmd(input shbgs_row_t r);
    int n;
    int t1;
    logic sg;
    logic sc;
    logic [3:0] prev;
    sg = 0;
    sc = 0;
    t1 = 0;
    prev = {hs_a[1:0], ls_a[1:0]};
    mode = r.m;
    hold = r.h;
    cs_n = 0;
    @(negedge clk) cs_n = 1;
    for (n = 1; n <= 100 && {hs_a[1:0], ls_a[1:0]} !== r.e; n++) begin
      @(negedge clk);
      if (t1 == 0 && {hs_a[1:0], ls_a[1:0]} !== prev) t1 = n;
      if (hs_a[1:0] === SHBGS_DRV_DISCHARGE && ls_a[1:0] === SHBGS_DRV_DISCHARGE) sg = 1;
      if (hs_a[1:0] === SHBGS_DRV_CHARGE || ls_a[1:0] === SHBGS_DRV_CHARGE) sc = 1;
    end
    chk("final actions", 5'(r.e), 5'({hs_a[1:0], ls_a[1:0]}));
    if (n > 100) summarize();
    chk("guard phase", 5'(r.g), 5'(sg));
    chk("charge phase", 5'(r.c), 5'(sc));
    chk("latency ok", 5'h1, 5'(t1 > 0 && t1 <= CMD_DELAY_CYC));
    chk("hold level", 5'(r.h ? HOLD_HIGH_CODE : HOLD_LOW_CODE), 5'(hs_l[3:0]));
    chk("last bridge", 5'({hs_a[1:0], ls_a[1:0]}), 5'({hs_a[15:14], ls_a[15:14]}));
  endtask
  initial begin
    srst = 1;
    cs_n = 1;
    pas = 0;
    hold = 0;
    overcurrent_shutdown_en = 0;
    flt = 0;
    mode = 0;
    pmap = 8'h00;
    err_total = 0;
    checks = 0;
    repeat (12) @(negedge clk);
    chk("code in reset", 5'h00, hoc);
    srst = 0;
    for (int i = 0; i < 20 && act !== 1'b1; i++) @(negedge clk);
    chk("active", 5'h1, 5'(act));
    if (act !== 1'b1) summarize();
    chk("hard-off code", HARD_OFF_CODE, hoc);
    foreach (rows[i]) cmd(rows[i]);
    cmd('{2'h2, 1'h0, 1'h0, 1'h1, 4'hc});
    pmap = 8'h80;
    cs_n = 0;
    @(negedge clk) cs_n = 1;
    repeat (20) @(negedge clk);
    chk("mapped bridge", 5'h0, 5'({hs_a[15:14], ls_a[15:14]}));
    chk("unmapped bridge", 5'hc, 5'({hs_a[1:0], ls_a[1:0]}));
    flt = 5'h10;
    repeat (10) @(negedge clk);
    chk("oc ungated", 5'h0, 5'(foff));
    overcurrent_shutdown_en = 1;
    repeat (10) @(negedge clk);
    chk("oc gated", 5'h1, 5'(foff));
    chk("fault discharge", 5'(SHBGS_DRV_DISCHARGE), 5'(hs_a[1:0]));
    flt = 0;
    overcurrent_shutdown_en = 0;
    for (int i = 0; i < 4; i++) begin
      repeat (10) @(negedge clk);
      flt = 5'(1 << i);
      repeat (10) @(negedge clk);
      chk("fault off", 5'h1, 5'(foff));
      flt = 0;
    end
    chk("no shoot-through", 5'h0, 5'(shot));
    pas = 1;
    repeat (10) @(negedge clk);
    chk("passive", 5'h0, 5'(act));
    srst = 1;
    repeat (2) @(negedge clk);
    chk("reset actions", 5'h0, 5'(hs_a[1:0] | ls_a[1:0]));
    summarize();
  end
endmodule
